// file: src/psc_pkg.sv
// Package for the power-on status clear block: constants and carrier types
package psc_pkg;

    // ****************************************************************
    // Widths, power-on and reset values, argument limit and query answers
    // ****************************************************************
    localparam int          ARG_W          = 32;
    localparam int          MASK_W         = 8;
    localparam logic [7:0]  DEV_MASK_CLEAR = 8'hFF;
    localparam logic [7:0]  SRQ_MASK_CLEAR = 8'h00;
    localparam logic [7:0]  EVT_MASK_CLEAR = 8'h00;
    localparam logic [7:0]  MASK_RESET     = 8'h00;
    localparam logic        FLAG_RESET     = 1'b0;
    localparam logic [31:0] ARG_MAX        = 32'h0000_FFFF;
    localparam logic [31:0] QUERY_TRUE     = 32'h0000_0001;
    localparam logic [31:0] QUERY_FALSE    = 32'h0000_0000;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [MASK_W-1:0] devMask;
        logic [MASK_W-1:0] srqMask;
        logic [MASK_W-1:0] evtMask;
    } masks_s;

    typedef struct packed {
        logic             write;
        logic             query;
        logic [ARG_W-1:0] arg;
    } cmd_s;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_POWER_UP,
        ST_SAVE
    } phase_e;

    typedef struct packed {
        phase_e           phase;
        logic             clearFlag;
        logic             srqBlocked;
        masks_s           masks;
        masks_s           nvMasksOut;
        logic             nvFlagOut;
        logic             nvWrite;
        logic             warn;
        logic             answerValid;
        logic [ARG_W-1:0] answer;
        logic             loaded;
    } state_s;

endpackage : psc_pkg

// file: src/power_on_status_clear_control.sv
// Power-on status clear flag and enable mask restore logic
// Contract
// - At power-on with the flag true, the device mask loads 255 and the other two masks load 0.
// - With the flag false, the masks are saved to nonvolatile store on power loss and reloaded.
// - Writing 0 clears the flag, disabling power-on clearing and allowing service requests.
// - Writing a nonzero value up to ARG_MAX sets the flag and suppresses service requests after power-on.
// - A written argument beyond the accepted range raises an execution warning.
// - A query returns the flag as a number, 1 meaning true.
`timescale 1ns/1ps
module power_on_status_clear_control
    import psc_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   resetn,
    input  wire cmd_s   cmd,
    input  wire logic   powerFail,
    input  wire masks_s nvMasksIn,
    input  wire logic   nvFlagIn,
    input  wire masks_s hostMasks,
    input  wire logic   hostMasksWrite,
    output logic        clearFlag,
    output masks_s      masks,
    output logic        srqBlocked,
    output masks_s      nvMasksOut,
    output logic        nvFlagOut,
    output logic        nvWrite,
    output logic        warn,
    output logic        answerValid,
    output logic [31:0] answer
);

    // ****************************************************************
    // Power-fail synchroniser
    // ****************************************************************
    logic failMeta;
    logic failSync;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            failMeta <= 1'b0;
            failSync <= 1'b0;
        end else begin
            failMeta <= powerFail;
            failSync <= failMeta;
        end
    end

    // ****************************************************************
    // Argument decoding
    // ****************************************************************
    function automatic logic argOutOfRange(input logic [ARG_W-1:0] arg);
        return arg > ARG_MAX;
    endfunction : argOutOfRange

    function automatic logic argSetsFlag(input logic [ARG_W-1:0] arg);
        return arg != '0;
    endfunction : argSetsFlag

    // ****************************************************************
    // State
    // ****************************************************************
    state_s st;
    state_s next_st;

    always_comb begin
        next_st             = st;
        next_st.nvWrite     = 1'b0;
        next_st.warn        = 1'b0;
        next_st.answerValid = 1'b0;
        unique case (st.phase)
            ST_POWER_UP: begin
                // Flag comes from nonvolatile store
                next_st.clearFlag = nvFlagIn;
                if (nvFlagIn) begin
                    next_st.masks.devMask = DEV_MASK_CLEAR;
                    next_st.masks.srqMask = SRQ_MASK_CLEAR;
                    next_st.masks.evtMask = EVT_MASK_CLEAR;
                end else begin
                    next_st.masks = nvMasksIn;
                end
                next_st.srqBlocked = nvFlagIn;
                next_st.loaded     = 1'b1;
                next_st.phase      = ST_RUN;
            end
            ST_RUN: begin
                if (hostMasksWrite) begin
                    next_st.masks = hostMasks;
                end
                if (cmd.write) begin
                    if (argOutOfRange(cmd.arg)) begin
                        next_st.warn = 1'b1;
                    end else begin
                        next_st.clearFlag  = argSetsFlag(cmd.arg);
                        next_st.srqBlocked = argSetsFlag(cmd.arg) && st.srqBlocked;
                        next_st.nvFlagOut  = argSetsFlag(cmd.arg);
                        next_st.nvMasksOut = st.masks;
                        next_st.nvWrite    = 1'b1;
                    end
                end
                if (cmd.query) begin
                    next_st.answerValid = 1'b1;
                    next_st.answer      = st.clearFlag ? QUERY_TRUE : QUERY_FALSE;
                end
                if (failSync) begin
                    next_st.phase = ST_SAVE;
                end
            end
            ST_SAVE: begin
                // Hold here until failSync drops, then reload as at power-on; one save per loss
                if (st.loaded) begin
                    next_st.nvMasksOut = st.clearFlag ? st.nvMasksOut : st.masks;
                    next_st.nvFlagOut  = st.clearFlag;
                    next_st.nvWrite    = 1'b1;
                    next_st.loaded     = 1'b0;
                end
                if (!failSync) begin
                    next_st.phase = ST_POWER_UP;
                end
            end
            default: next_st.phase = ST_POWER_UP;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st             <= '0;
            st.phase       <= ST_POWER_UP;
            st.clearFlag   <= FLAG_RESET;
            st.masks       <= {MASK_RESET, MASK_RESET, MASK_RESET};
            st.srqBlocked  <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign clearFlag   = st.clearFlag;
    assign masks       = st.masks;
    assign srqBlocked  = st.srqBlocked;
    assign nvMasksOut  = st.nvMasksOut;
    assign nvFlagOut   = st.nvFlagOut;
    assign nvWrite     = st.nvWrite;
    assign warn        = st.warn;
    assign answerValid = st.answerValid;
    assign answer      = st.answer;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Power-up load; the release edge itself is left out
    pwr_clear_load_a: assert property (
        resetn && st.phase == ST_POWER_UP && nvFlagIn |=> masks.devMask == DEV_MASK_CLEAR
            && masks.srqMask == SRQ_MASK_CLEAR && masks.evtMask == EVT_MASK_CLEAR)
        else $error("masks not cleared at power-on");
    pwr_restore_a: assert property (
        resetn && st.phase == ST_POWER_UP && !nvFlagIn |=> masks == $past(nvMasksIn))
        else $error("masks not restored");
    srq_powerup_a: assert property (
        resetn && st.phase == ST_POWER_UP |=> srqBlocked == $past(nvFlagIn))
        else $error("service request block not loaded at power-on");
    power_flag_a: assert property (
        resetn && st.phase == ST_POWER_UP |=> clearFlag == $past(nvFlagIn))
        else $error("flag not loaded from store at power-on");

    // Command handling
    write_zero_a: assert property (
        st.phase == ST_RUN && cmd.write && cmd.arg == '0 |=> !clearFlag && !srqBlocked)
        else $error("zero write did not clear flag");
    write_set_a: assert property (
        st.phase == ST_RUN && cmd.write && cmd.arg != '0 && cmd.arg <= ARG_MAX |=> clearFlag)
        else $error("nonzero write did not set flag");
    write_store_a: assert property (
        st.phase == ST_RUN && cmd.write && !argOutOfRange(cmd.arg)
            |=> nvWrite && nvMasksOut == $past(masks))
        else $error("accepted write not stored");
    range_warn_a: assert property (
        st.phase == ST_RUN && cmd.write && cmd.arg > ARG_MAX |=> warn && $stable(clearFlag))
        else $error("no warning on bad argument");
    warn_quiet_a: assert property (
        !(st.phase == ST_RUN && cmd.write) |=> !warn)
        else $error("warning without a write");
    query_value_a: assert property (
        st.phase == ST_RUN && cmd.query |=> answerValid && answer == {31'd0, $past(clearFlag)})
        else $error("query answer wrong");
    answer_quiet_a: assert property (
        !(st.phase == ST_RUN && cmd.query) |=> !answerValid)
        else $error("answer without a query");
    flag_hold_a: assert property (
        st.phase == ST_RUN && !cmd.write |=> $stable(clearFlag))
        else $error("flag changed without a write");
    srq_no_rise_a: assert property (
        st.phase != ST_POWER_UP && !srqBlocked |=> !srqBlocked)
        else $error("service request block set outside power-on");

    // Power-loss save
    save_on_loss_a: assert property (
        st.phase == ST_SAVE && st.loaded && !clearFlag |=> nvWrite && nvMasksOut == $past(masks))
        else $error("masks not saved on power loss");
    save_keep_a: assert property (
        st.phase == ST_SAVE && st.loaded && clearFlag |=> nvMasksOut == $past(nvMasksOut))
        else $error("stored masks overwritten with flag set");
    save_flag_a: assert property (
        st.phase == ST_SAVE && st.loaded |=> nvWrite && nvFlagOut == $past(clearFlag))
        else $error("flag not saved on power loss");
    save_once_a: assert property (
        st.phase == ST_SAVE && !st.loaded |=> !nvWrite)
        else $error("second save in one power loss");
    save_hold_a: assert property (
        st.phase == ST_SAVE |=> $stable(clearFlag))
        else $error("flag changed during save");
    flag_persist_a: assert property (
        nvWrite |-> nvFlagOut == clearFlag)
        else $error("stored flag differs");

    cov_query_c: cover property (answerValid && answer == QUERY_TRUE);
    cov_clear_c: cover property (st.phase == ST_POWER_UP && nvFlagIn);
    cov_restore_c: cover property (st.phase == ST_POWER_UP && !nvFlagIn);
    cov_warn_c: cover property (warn);
    cov_save_c: cover property (st.phase == ST_SAVE && nvWrite);

endmodule : power_on_status_clear_control

// file: bench/nv_store_model.sv
// Nonvolatile store model facing the save and restore ports of the block
`timescale 1ns/1ps
module nv_store_model
    import psc_pkg::*;
(
    input  wire logic   clk,
    input  wire masks_s nvMasksOut,
    input  wire logic   nvFlagOut,
    input  wire logic   nvWrite,
    output masks_s      nvMasksIn,
    output logic        nvFlagIn
);
    // ****************************************************************
    // Storage, untouched by reset
    // ****************************************************************
    initial begin
        nvMasksIn = 24'h3C_A55A;
        nvFlagIn  = 1'b0;
    end
    always @(posedge clk) begin
        if (nvWrite === 1'b1) begin
            nvMasksIn <= nvMasksOut;
            nvFlagIn  <= nvFlagOut;
        end
    end
endmodule : nv_store_model

// file: bench/test_power_on_status_clear_control.sv
// Self-checking bench for the power-on status clear block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module test_power_on_status_clear_control
    import psc_pkg::*;
;
    typedef struct {logic [31:0] arg; logic flag; logic wrn;} row_s;
    logic        clk = 0, resetn = 0, powerFail = 0, hostMasksWrite = 0;
    logic        nvFlagIn, clearFlag, srqBlocked, nvFlagOut, nvWrite, warn, answerValid;
    logic [31:0] answer;
    cmd_s        cmd = '0;
    masks_s      hostMasks = '0, nvMasksIn, masks, nvMasksOut;
    int          err_total = 0, n_tests = 0;
    row_s        rows [6] = '{'{32'h0000_0000, 1'b0, 1'b0}, '{32'h0000_0001, 1'b1, 1'b0},
        '{32'h0001_0000, 1'b1, 1'b1}, '{32'h0000_0000, 1'b0, 1'b0},
        '{32'h0000_FFFF, 1'b1, 1'b0}, '{32'h8000_0000, 1'b1, 1'b1}};
    // ****************************************************************
    // Design, store and stimulus
    // ****************************************************************
    power_on_status_clear_control uut (.clk(clk), .resetn(resetn), .cmd(cmd),
        .powerFail(powerFail), .nvMasksIn(nvMasksIn), .nvFlagIn(nvFlagIn),
        .hostMasks(hostMasks), .hostMasksWrite(hostMasksWrite), .clearFlag(clearFlag),
        .masks(masks), .srqBlocked(srqBlocked), .nvMasksOut(nvMasksOut),
        .nvFlagOut(nvFlagOut), .nvWrite(nvWrite), .warn(warn),
        .answerValid(answerValid), .answer(answer));
    nv_store_model store (.clk(clk), .nvMasksOut(nvMasksOut), .nvFlagOut(nvFlagOut),
        .nvWrite(nvWrite), .nvMasksIn(nvMasksIn), .nvFlagIn(nvFlagIn));
    always #4 clk = ~clk;
    task automatic issue(input logic wr, input logic [31:0] a);
        @(posedge clk) cmd <= '{write: wr, query: !wr, arg: a};
        @(posedge clk) cmd <= '0;
        #1;
    endtask : issue
    task automatic host_write(input masks_s m);
        @(posedge clk) hostMasks <= m;
        hostMasksWrite <= 1'b1;
        @(posedge clk) hostMasksWrite <= 1'b0;
    endtask : host_write
    // Power loss, then a power-on reset once the save has landed
    task automatic power_cycle();
        @(posedge clk) powerFail <= 1'b1;
        repeat (8) @(posedge clk);
        resetn <= 1'b0;
        powerFail <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask : power_cycle
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        #100000;
        err_total++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK("masks", 24'h3C_A55A, masks)
        `CHK("clearFlag", 1'b0, clearFlag)
        `CHK("srqBlocked", 1'b0, srqBlocked)
        foreach (rows[i]) begin
            issue(1'b1, rows[i].arg);
            `CHK("warn", rows[i].wrn, warn)
            `CHK("clearFlag", rows[i].flag, clearFlag)
            `CHK("nvWrite", !rows[i].wrn, nvWrite)
            `CHK("nvFlagOut", rows[i].flag, nvFlagOut)
            issue(1'b0, 32'h0000_0000);
            `CHK("answer", rows[i].flag ? QUERY_TRUE : QUERY_FALSE, answer)
            `CHK("answerValid", 1'b1, answerValid)
        end
        `CHK("nvMasksOut", 24'h3C_A55A, nvMasksOut)
        host_write(24'h12_3456);
        power_cycle();
        `CHK("masks", {DEV_MASK_CLEAR, SRQ_MASK_CLEAR, EVT_MASK_CLEAR}, masks)
        `CHK("srqBlocked", 1'b1, srqBlocked)
        `CHK("clearFlag", 1'b1, clearFlag)
        issue(1'b1, 32'h0000_0000);
        `CHK("srqBlocked", 1'b0, srqBlocked)
        host_write(24'h12_3456);
        power_cycle();
        `CHK("masks", 24'h12_3456, masks)
        `CHK("clearFlag", 1'b0, clearFlag)
        `CHK("srqBlocked", 1'b0, srqBlocked)
        complete_run();
    end
endmodule : test_power_on_status_clear_control
